// [pcw_clock_ctrl.sv]
// clock control top: pll modes, core divider, limp mode, watchdog, low power
// What this block does
// - selected clock halved before core unless divider bypass bit is set.
// - pll off bit, after multiplier zero, disables pll; cpu runs from input.
// - reset, zero multiplier, or relock all give bypass with pll running.
// - non-zero multiplier: bypass until lock, then oscillator times n over two.
// - lost oscillator switches to limp clock whenever the pll off bit is clear.
// - in bypass mode, cpu clock moves to limp clock automatically unless pll off bit is set.
// - limp fallback only armed after oscillator seen at least once.
// - watchdog counter freezes while oscillator is missing.
// - clock failure resets device and sets missing clock flag.
// - 8-bit up counter; at maximum, reset low for 512 cycles.
// - key 0x55 then 0xAA clears watchdog counter.
// - in standby only watchdog runs; its interrupt can wake device.
// - in idle watchdog interrupt reaches cpu and ends idle.
// - in halt oscillator and pll stop; watchdog cannot wake.
// - mode bits 00 idle, 01 standby, 1x halt.
// - idle exits on reset, watchdog, enabled interrupt or nmi.
// - standby and halt exit sources as listed, watchdog only for standby.
// - selected port A pins qualified for programmed cycles before wake.
// - cpu clock runs in idle, stops in standby and halt.
// - output pins keep their state across low-power modes.
// - multiplier 4 bits: 0 bypass, 1 to 10 multiply, 11 to 15 reserved.
// - pll needs 131072 oscillator cycles to settle after a change.
`timescale 1ns/100ps
module pcw_clock_ctrl
  import pcw_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                osc_present,
  input  wire logic                mult_wr,
  input  wire logic [MULT_W-1:0]   mult_wdata,
  input  wire logic                core_divider_bypass,
  input  wire logic                pll_disable_bit,
  input  wire logic                wd_enable,
  input  wire logic                wd_key_wr,
  input  wire logic [WD_W-1:0]     wd_key_data,
  input  wire logic                wd_wake_en,
  input  wire logic [1:0]          low_power_select_bits,
  input  wire logic                lp_enter,
  input  wire logic [QUAL_W-1:0]   wake_qual_cycles,
  input  wire logic [PORTA_W-1:0]  wake_pin_select,
  input  wire logic [PORTA_W-1:0]  port_a_pins,
  input  wire logic                external_nonmaskable_interrupt_n,
  input  wire logic                enabled_irq,
  input  wire logic                debugger_wake,
  input  wire logic                missing_clock_clear,
  output pcw_pll_mode_t            pll_mode,
  output logic [MULT_W-1:0]        pll_multiplier_control,
  output logic [MULT_W-1:0]        effective_multiplier,
  output logic                     core_div2_active,
  output logic                     pll_lock_flag,
  output logic                     limp_clock_select,
  output logic                     missing_clock_flag,
  output logic                     device_reset,
  output logic [WD_W-1:0]          wd_count,
  output logic                     watchdog_reset_output_n,
  output logic                     watchdog_wake_interrupt,
  output pcw_lp_mode_t             lp_mode,
  output logic                     cpu_clock_en,
  output logic                     osc_enable,
  output logic                     lp_wake
);
  import pcw_pkg::*;

  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // =====================================
  // input synchronisers
  logic [PORTA_W-1:0] pa_s1_r;
  logic [PORTA_W-1:0] pa_s2_r;
  logic [2:0]         s1_r;
  logic [2:0]         s2_r;
  logic               osc_ok;
  logic               nmi_low;
  logic               dbg_wake;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pa_s1_r <= '1;
      pa_s2_r <= '1;
      s1_r    <= 3'h2;
      s2_r    <= 3'h2;
    end else begin
      pa_s1_r <= port_a_pins;
      pa_s2_r <= pa_s1_r;
      s1_r    <= {debugger_wake, external_nonmaskable_interrupt_n, osc_present};
      s2_r    <= s1_r;
    end
  end
  assign osc_ok   = s2_r[0];
  assign nmi_low  = !s2_r[1];
  assign dbg_wake = s2_r[2];

  // =====================================
  // pll multiplier and lock timer
  logic [LCW-1:0] lock_cnt_r;
  logic           osc_seen_r;

  function automatic logic mult_legal(input logic [MULT_W-1:0] m);
    return m <= MULT_MAX;
  endfunction : mult_legal

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // power-up counts as a relock, so the flag starts low
      pll_multiplier_control <= MULT_BYPASS;
      lock_cnt_r             <= LCW'(LOCK_CYCLES);
      pll_lock_flag          <= 1'b0;
    end else if (mult_wr && mult_legal(mult_wdata) && !core_divider_bypass) begin
      pll_multiplier_control <= mult_wdata;
      lock_cnt_r             <= LCW'(LOCK_CYCLES);
      pll_lock_flag          <= 1'b0;
    end else if (lock_cnt_r != '0) begin
      if (osc_ok) begin
        lock_cnt_r <= lock_cnt_r - 1'b1;
      end
    end else begin
      pll_lock_flag <= !pll_disable_bit;
    end
  end

  // =====================================
  // pll mode, limp select, core divider
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_seen_r <= 1'b0;
    end else if (osc_ok) begin
      osc_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_mode             <= PCW_PLL_BYPASS;
      effective_multiplier <= MULT_BYPASS;
    end else begin
      if (pll_disable_bit && pll_multiplier_control == MULT_BYPASS) begin
        pll_mode             <= PCW_PLL_OFF;
        effective_multiplier <= MULT_BYPASS;
      end else if (pll_multiplier_control == MULT_BYPASS || !pll_lock_flag) begin
        pll_mode             <= PCW_PLL_BYPASS;
        effective_multiplier <= MULT_BYPASS;
      end else begin
        pll_mode             <= PCW_PLL_ENABLED;
        effective_multiplier <= pll_multiplier_control;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_div2_active <= 1'b1;
    end else begin
      core_div2_active <= !core_divider_bypass;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      limp_clock_select <= 1'b0;
    end else begin
      // pll off bit set means no pll to limp on
      limp_clock_select <= !osc_ok && osc_seen_r && !pll_disable_bit;
    end
  end

  // =====================================
  // missing clock reset and flag
  logic [4:0] miss_cnt_r;
  logic       miss_event;
  assign miss_event = !osc_ok && osc_seen_r && miss_cnt_r == 5'(MISS_LIMIT);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      miss_cnt_r <= '0;
    end else if (osc_ok) begin
      miss_cnt_r <= '0;
    end else if (osc_seen_r && miss_cnt_r != 5'(MISS_LIMIT)) begin
      miss_cnt_r <= miss_cnt_r + 5'h01;
    end
  end

  // flag survives the device reset it causes; set beats clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      missing_clock_flag <= 1'b0;
    end else if (miss_event) begin
      missing_clock_flag <= 1'b1;
    end else if (missing_clock_clear) begin
      missing_clock_flag <= 1'b0;
    end
  end

  // =====================================
  // watchdog
  pcw_wd_if wdb ();
  logic wd_run;
  assign wd_run       = wd_enable && lp_mode != PCW_HALT;
  assign wdb.osc_ok   = osc_ok && lp_mode != PCW_HALT;
  assign wdb.run_en   = wd_run;
  assign wdb.key_wr   = wd_key_wr;
  assign wdb.key_data = wd_key_data;

  pcw_watchdog u_wd (
    .mclk (mclk),
    .rst  (rst),
    .wdb  (wdb)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wd_count                <= '0;
      watchdog_reset_output_n <= 1'b1;
      watchdog_wake_interrupt <= 1'b0;
      device_reset            <= 1'b0;
    end else begin
      wd_count                <= wdb.count;
      watchdog_reset_output_n <= !wdb.reset_active;
      watchdog_wake_interrupt <= wdb.expire && wd_wake_en;
      device_reset            <= wdb.reset_active || miss_event;
    end
  end

  // =====================================
  // low-power modes
  logic pin_wake;

  pcw_wake_qual #(.WIDTH(PORTA_W)) u_wq (
    .mclk        (mclk),
    .rst         (rst),
    .pins_sync   (pa_s2_r),
    .select      (wake_pin_select),
    .qual_cycles (wake_qual_cycles),
    .wake        (pin_wake)
  );

  function automatic pcw_lp_mode_t lp_decode(input logic [1:0] bits);
    pcw_lp_mode_t mode;
    case (bits)
      LPM_IDLE:    mode = PCW_IDLE;
      LPM_STANDBY: mode = PCW_STANDBY;
      default:     mode = PCW_HALT;
    endcase
    return mode;
  endfunction : lp_decode

  pcw_lp_mode_t lp_next;
  logic         wake_now;
  assign lp_next = lp_decode(low_power_select_bits);

  always_comb begin
    case (lp_mode)
      PCW_RUN:     wake_now = 1'b0;
      PCW_IDLE:    wake_now = wdb.expire || enabled_irq || nmi_low;
      PCW_STANDBY: wake_now = (wdb.expire && wd_wake_en) || pin_wake
                              || dbg_wake || nmi_low;
      PCW_HALT:    wake_now = pin_wake || nmi_low || dbg_wake;
      default:     wake_now = 1'b0;
    endcase
  end

  // =====================================
  // mode register; a wake always returns to run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_mode <= PCW_RUN;
    end else if (lp_mode == PCW_RUN) begin
      if (lp_enter) begin
        lp_mode <= lp_next;
      end
    end else if (wake_now) begin
      lp_mode <= PCW_RUN;
    end
  end

  // one-cycle wake pulse for the interrupt logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_wake <= 1'b0;
    end else begin
      lp_wake <= lp_mode != PCW_RUN && wake_now;
    end
  end

  // clock gates switch on the same edge as the mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_clock_en <= 1'b1;
      osc_enable   <= 1'b1;
    end else if (lp_mode == PCW_RUN && lp_enter) begin
      cpu_clock_en <= lp_next == PCW_IDLE;
      osc_enable   <= lp_next != PCW_HALT;
    end else if (lp_mode != PCW_RUN && wake_now) begin
      cpu_clock_en <= 1'b1;
      osc_enable   <= 1'b1;
    end
  end
  // output pins are not touched here, so they hold their state
endmodule : pcw_clock_ctrl

// [pcw_pkg.sv]
// constants and types shared by the clock, watchdog and low-power block
package pcw_pkg;
  localparam int          MULT_W       = 4;
  localparam logic [3:0]  MULT_BYPASS  = 4'h0;
  localparam logic [3:0]  MULT_MAX     = 4'hA;
  localparam int          PLL_LOCK_CYC = 131072;
  localparam int          WD_W         = 8;
  localparam logic [7:0]  WD_MAX       = 8'hFF;
  localparam logic [7:0]  WD_KEY1      = 8'h55;
  localparam logic [7:0]  WD_KEY2      = 8'hAA;
  localparam int          WD_RST_CYC   = 512;
  localparam int          MISS_LIMIT   = 16;
  localparam int          QUAL_W       = 6;
  localparam int          PORTA_W      = 32;
  localparam logic [1:0]  LPM_IDLE     = 2'h0;
  localparam logic [1:0]  LPM_STANDBY  = 2'h1;
  typedef enum logic [1:0] {PCW_PLL_OFF, PCW_PLL_BYPASS, PCW_PLL_ENABLED} pcw_pll_mode_t;
  typedef enum logic [1:0] {PCW_RUN, PCW_IDLE, PCW_STANDBY, PCW_HALT} pcw_lp_mode_t;
endpackage : pcw_pkg

// [pcw_wd_if.sv]
// watchdog signals between the top and the watchdog module
`timescale 1ns/100ps
interface pcw_wd_if;
  logic       osc_ok;
  logic       run_en;
  logic       key_wr;
  logic [7:0] key_data;
  logic [7:0] count;
  logic       expire;
  logic       reset_active;
  modport top (output osc_ok, run_en, key_wr, key_data, input count, expire, reset_active);
  modport wd  (input osc_ok, run_en, key_wr, key_data, output count, expire, reset_active);
endinterface : pcw_wd_if

// [pcw_watchdog.sv]
// 8-bit watchdog counter with key sequence and reset pulse timer
`timescale 1ns/100ps
module pcw_watchdog
  import pcw_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  pcw_wd_if.wd      wdb
);
  logic       key_armed_r;
  logic [7:0] count_r;
  logic [9:0] pulse_r;
  logic       expire_r;

  // =====================================
  // counter, frozen without oscillator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r     <= 8'h00;
      key_armed_r <= 1'b0;
    end else begin
      if (wdb.key_wr) begin
        key_armed_r <= (wdb.key_data == WD_KEY1);
      end
      if (wdb.key_wr && key_armed_r && wdb.key_data == WD_KEY2) begin
        count_r <= 8'h00;
      end else if (!wdb.run_en || pulse_r != 10'h000) begin
        count_r <= 8'h00;
      end else if (wdb.osc_ok) begin
        count_r <= (count_r == WD_MAX) ? 8'h00 : count_r + 8'h01;
      end
    end
  end

  // =====================================
  // reset pulse, timed on oscillator cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_r  <= 10'h000;
      expire_r <= 1'b0;
    end else begin
      expire_r <= wdb.run_en && wdb.osc_ok && count_r == WD_MAX && pulse_r == 10'h000;
      if (expire_r) begin
        pulse_r <= 10'(WD_RST_CYC);
      end else if (pulse_r != 10'h000 && wdb.osc_ok) begin
        pulse_r <= pulse_r - 10'h001;
      end
    end
  end

  assign wdb.count        = count_r;
  assign wdb.expire       = expire_r;
  assign wdb.reset_active = (pulse_r != 10'h000);
endmodule : pcw_watchdog

// [pcw_wake_qual.sv]
// port A wake pin qualifier: a selected pin must stay low for N cycles
`timescale 1ns/100ps
module pcw_wake_qual
  import pcw_pkg::*;
#(
  parameter int WIDTH = PORTA_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  pins_sync,
  input  wire logic [WIDTH-1:0]  select,
  input  wire logic [QUAL_W-1:0] qual_cycles,
  output logic                   wake
);
  logic [QUAL_W-1:0] cnt_r;
  logic              any_low;

  assign any_low = |(~pins_sync & select);

  // =====================================
  // qualify selected low level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      wake  <= 1'b0;
    end else begin
      if (!any_low) begin
        cnt_r <= '0;
        wake  <= 1'b0;
      end else if (cnt_r >= qual_cycles) begin
        wake  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : pcw_wake_qual

// [pcw_clock_ctrl_assertions.sv]
// concurrent checks on the ports of the clock, watchdog and low-power block
`timescale 1ns/100ps
module pcw_clock_ctrl_assertions
  import pcw_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYC
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              mult_wr,
  input wire logic [MULT_W-1:0] mult_wdata,
  input wire logic              core_divider_bypass,
  input wire logic              lp_enter,
  input wire logic [1:0]        low_power_select_bits,
  input wire pcw_pll_mode_t     pll_mode,
  input wire logic              pll_lock_flag,
  input wire logic              core_div2_active,
  input wire logic              device_reset,
  input wire logic              watchdog_reset_output_n,
  input wire pcw_lp_mode_t      lp_mode,
  input wire logic              cpu_clock_en,
  input wire logic              osc_enable,
  input wire logic              lp_wake
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // helper counters, too long for a repetition
  logic acc;
  int   lk_cnt;
  int   lo_cnt;
  assign acc = mult_wr && (mult_wdata <= MULT_MAX) && !core_divider_bypass;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) lk_cnt <= 0;
    else if (acc) lk_cnt <= 0;
    else lk_cnt <= lk_cnt + 1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) lo_cnt <= 0;
    else if (watchdog_reset_output_n) lo_cnt <= 0;
    else lo_cnt <= lo_cnt + 1;
  end
  // ==========================================================
  // assertions
  a_div_follows_bit: assert property ($stable(core_divider_bypass) |->
    core_div2_active == !core_divider_bypass) else $error("divider state wrong");
  a_lock_drops_write: assert property (acc |=> !pll_lock_flag)
    else $error("lock flag not cleared by write");
  a_lock_waits_full: assert property ($rose(pll_lock_flag) |-> lk_cnt >= LOCK_CYCLES)
    else $error("lock flag set too early");
  a_no_enable_unlocked: assert property ((!pll_lock_flag) [*2] |->
    pll_mode != PCW_PLL_ENABLED) else $error("enabled while unlocked");
  a_wd_pulse_length: assert property ($rose(watchdog_reset_output_n) |-> lo_cnt == WD_RST_CYC)
    else $error("watchdog pulse length wrong");
  a_wd_resets_device: assert property ($fell(watchdog_reset_output_n) |-> device_reset)
    else $error("no device reset with watchdog pulse");
  a_lp_mode_select: assert property (lp_enter && lp_mode == PCW_RUN |=> lp_mode ==
    ($past(low_power_select_bits[1]) ? PCW_HALT :
     ($past(low_power_select_bits[0]) ? PCW_STANDBY : PCW_IDLE)))
    else $error("wrong low-power mode");
  a_standby_clk_off: assert property ((lp_mode == PCW_STANDBY) [*2] |->
    !cpu_clock_en && osc_enable) else $error("standby clocks wrong");
  a_halt_all_off: assert property ((lp_mode == PCW_HALT) [*2] |->
    !cpu_clock_en && !osc_enable) else $error("halt clocks wrong");
  a_wake_one_pulse: assert property (lp_wake |->
    (lp_mode == PCW_RUN && cpu_clock_en) ##1 !lp_wake) else $error("wake pulse wrong");
  c_lock: cover property ($rose(pll_lock_flag));
  c_wd_fire: cover property ($fell(watchdog_reset_output_n));
  c_halt: cover property (lp_mode == PCW_HALT);
  c_wake: cover property (lp_wake);
endmodule : pcw_clock_ctrl_assertions

bind pcw_clock_ctrl pcw_clock_ctrl_assertions #(.LOCK_CYCLES(LOCK_CYCLES))
  pcw_clock_ctrl_assertions_i (.*);

// [pcw_clock_ctrl_tb.sv]
// self-checking bench for the clock, watchdog and low-power block
`timescale 1ns/100ps
module pcw_clock_ctrl_tb;
  import pcw_pkg::*;
  localparam int LK = 16;
  logic mclk, rst, osc_present, mult_wr, core_divider_bypass, pll_disable_bit;
  logic wd_enable, wd_key_wr, wd_wake_en, lp_enter, enabled_irq, debugger_wake;
  logic external_nonmaskable_interrupt_n, missing_clock_clear;
  logic [3:0]    mult_wdata, pll_multiplier_control, effective_multiplier, cur, m;
  logic [7:0]    wd_key_data, wd_count, w;
  logic [1:0]    low_power_select_bits;
  logic [5:0]    wake_qual_cycles;
  logic [31:0]   wake_pin_select, port_a_pins;
  pcw_pll_mode_t pll_mode;
  pcw_lp_mode_t  lp_mode, em;
  logic core_div2_active, pll_lock_flag, limp_clock_select, missing_clock_flag;
  logic device_reset, watchdog_reset_output_n, watchdog_wake_interrupt;
  logic cpu_clock_en, osc_enable, lp_wake;
  int error_cnt, checks_done, n, q, p;
  logic [3:0] corner [5] = '{4'hB, 4'hF, 4'h0, 4'h1, 4'hA};

  pcw_clock_ctrl #(.LOCK_CYCLES(LK)) pcw_clock_ctrl_i (.*);

  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================================
  // shared tasks
  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk);
    #2;
  endtask : tick
  task automatic cmp(logic [15:0] got, logic [15:0] exp, string s);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %s got %0h exp %0h", $time, s, got, exp);
    end
  endtask : cmp
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // key writes held high across both bytes, never re-raised in one step
  task automatic keys(logic [7:0] a, logic [7:0] b);
    wd_key_wr = 1;
    wd_key_data = a;
    tick();
    wd_key_data = b;
    tick();
    wd_key_wr = 0;
  endtask : keys
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst, osc_present, external_nonmaskable_interrupt_n, cur} = {3'b111, 4'h0};
    {mult_wr, mult_wdata, core_divider_bypass, pll_disable_bit, wd_enable} = '0;
    {wd_key_wr, wd_key_data, wd_wake_en, low_power_select_bits, lp_enter} = '0;
    {wake_qual_cycles, wake_pin_select, enabled_irq, debugger_wake} = '0;
    missing_clock_clear = 0;
    port_a_pins = '1;
    n = $urandom(12719);
    tick(10);
    rst = 0;
    tick(3);
    cmp(pll_mode, PCW_PLL_BYPASS, "reset mode");
    cmp(core_div2_active, 1, "reset divider");
    cmp(watchdog_reset_output_n, 1, "reset wd output");
    cmp(lp_mode, PCW_RUN, "reset lp");
    for (int k = 0; k < 11; k++) begin
      m = (k < 6) ? 4'($urandom_range(15)) : corner[k-6];
      mult_wdata = m;
      mult_wr = 1;
      tick();
      mult_wr = 0;
      if (m > MULT_MAX) begin
        tick(2);
        cmp(pll_multiplier_control, cur, "reserved ignored");
      end else begin
        cur = m;
        tick();
        cmp(pll_lock_flag, 0, "lock clear");
        cmp(pll_mode, PCW_PLL_BYPASS, "bypass while locking");
        cmp(effective_multiplier, MULT_BYPASS, "ratio while locking");
        for (n = 0; n < LK + 10 && pll_lock_flag !== 1'b1; n++) tick();
        tick(2);
        cmp(pll_multiplier_control, m, "multiplier");
        cmp(effective_multiplier, m, "ratio");
        if (m != 0) cmp(pll_lock_flag, 1, "lock set");
        cmp(pll_mode, (m == 0) ? PCW_PLL_BYPASS : PCW_PLL_ENABLED, "mode");
      end
    end
    core_divider_bypass = 1;
    mult_wdata = 4'h3;
    mult_wr = 1;
    tick();
    mult_wr = 0;
    tick(2);
    cmp(core_div2_active, 0, "undivided");
    cmp(pll_multiplier_control, cur, "write refused");
    core_divider_bypass = 0;
    mult_wdata = 4'h0;
    mult_wr = 1;
    tick();
    mult_wr = 0;
    pll_disable_bit = 1;
    tick(3);
    cmp(core_div2_active, 1, "divided");
    cmp(pll_mode, PCW_PLL_OFF, "pll off");
    pll_disable_bit = 0;
    tick(3);
    // watchdog: clear, wrong order, then let it fire
    wd_enable = 1;
    tick(40);
    keys(WD_KEY1, WD_KEY2);
    tick();
    cmp(wd_count < 8'h05, 1, "key clears");
    tick(60);
    keys(WD_KEY2, WD_KEY1);
    tick();
    cmp(wd_count > 8'h30, 1, "reversed keys ignored");
    for (n = 0; n < 300 && watchdog_reset_output_n !== 1'b0; n++) tick();
    cmp(device_reset, 1, "device reset");
    for (n = 0; n < 600 && watchdog_reset_output_n === 1'b0; n++) tick();
    cmp(n, 512, "pulse length");
    wd_enable = 0;
    tick(5);
    // low-power settings 0 to 3, one wake source each; halt tried with debugger and with nmi
    for (int s = 0; s < 4; s++) begin
      em = s[1] ? PCW_HALT : (s[0] ? PCW_STANDBY : PCW_IDLE);
      p = $urandom_range(31);
      q = $urandom_range(20, 2);
      wake_pin_select = 32'h1 << p;
      wake_qual_cycles = 6'(q);
      low_power_select_bits = 2'(s);
      lp_enter = 1;
      tick();
      lp_enter = 0;
      tick();
      cmp(lp_mode, em, "mode entered");
      cmp(cpu_clock_en, em == PCW_IDLE, "cpu clock");
      cmp(osc_enable, em != PCW_HALT, "oscillator");
      port_a_pins = ~(32'h1 << (p ^ 1));
      tick(q + 8);
      cmp(lp_mode, em, "unselected pin");
      port_a_pins = '1;
      case (s)
        0: enabled_irq = 1;
        1: port_a_pins = ~(32'h1 << p);
        2: debugger_wake = 1;
        default: external_nonmaskable_interrupt_n = 0;
      endcase
      if (s == 1) begin
        tick(q);
        cmp(lp_mode, em, "pin still qualifying");
      end
      for (n = 0; n < 40 && lp_mode !== PCW_RUN; n++) tick();
      cmp(lp_mode, PCW_RUN, "woken");
      cmp(lp_wake, 1, "wake pulse");
      {enabled_irq, debugger_wake, external_nonmaskable_interrupt_n} = 3'b001;
      port_a_pins = '1;
      tick(4);
    end
    // watchdog expiry wakes idle and standby, then its reset pulse runs out
    wd_wake_en = 1;
    for (int s = 0; s < 2; s++) begin
      low_power_select_bits = s ? LPM_STANDBY : LPM_IDLE;
      wd_enable = 1;
      lp_enter = 1;
      tick();
      lp_enter = 0;
      for (n = 0; n < 300 && lp_mode !== PCW_RUN; n++) tick();
      cmp(watchdog_wake_interrupt, 1, "watchdog interrupt");
      cmp(lp_wake, 1, "watchdog wake");
      tick(2);
      cmp(watchdog_reset_output_n, 0, "expiry reset");
      for (n = 0; n < 600 && watchdog_reset_output_n !== 1'b1; n++) tick();
      wd_enable = 0;
      tick(3);
    end
    wd_wake_en = 0;
    // oscillator loss in bypass mode
    wd_enable = 1;
    keys(WD_KEY1, WD_KEY2);
    osc_present = 0;
    tick(6);
    cmp(limp_clock_select, 1, "limp clock");
    w = wd_count;
    tick(5);
    cmp(wd_count, w, "watchdog frozen");
    tick(20);
    cmp(missing_clock_flag, 1, "missing flag");
    wd_enable = 0;
    osc_present = 1;
    tick(4);
    missing_clock_clear = 1;
    tick();
    missing_clock_clear = 0;
    tick(2);
    cmp(missing_clock_flag, 0, "flag cleared");
    wrap_up();
  end
endmodule : pcw_clock_ctrl_tb
